/* logic/faiu_regs.svh */
// Register offsets, field positions, reset values and timing counts of the fault alarm unit
`ifndef FAIU_REGS_SVH
`define FAIU_REGS_SVH

// Register byte offsets
`define FAIU_CTRL_OFS     12'h000
`define FAIU_STATUS_OFS   12'h004
`define FAIU_HOURS_OFS    12'h008
`define FAIU_LOGCNT_OFS   12'h00c
`define FAIU_FAULT_OFS    12'h010
`define FAIU_LOG_OFS      12'h080
`define FAIU_LOG_END      12'h0f8

// Control field positions
`define FAIU_CTRL_HEAT    0
`define FAIU_CTRL_RESET   1
`define FAIU_CTRL_INVREL  2
`define FAIU_CTRL_EXTDIAG 3
`define FAIU_CTRL_CWIDE   4
`define FAIU_CTRL_EXTLAY  5
`define FAIU_CTRL_RANGE5  6
`define FAIU_CTRL_RST     7'h00

// Sizes
`define FAIU_LOG_DEPTH    30
`define FAIU_DAC_FULL     12'hfff
`define FAIU_CODE_CAL     10'h3ff

// Timing
`define FAIU_CLK_HZ       100000000
`define FAIU_STEP_MIN     6
`define FAIU_STEP_CYC     (64'(`FAIU_STEP_MIN) * 64'd60 * 64'(`FAIU_CLK_HZ))
`define FAIU_FAST_HZ      4
`define FAIU_SLOW_HZ      1
`define FAIU_FAST_HALF    (`FAIU_CLK_HZ / (2 * `FAIU_FAST_HZ))
`define FAIU_SLOW_HALF    (`FAIU_CLK_HZ / (2 * `FAIU_SLOW_HZ))

`endif

/* logic/faiu_pkg.sv */
// Types shared by the fault alarm unit
package faiu_pkg;
   typedef enum logic [1:0] {
      faiu_cls_none,
      faiu_cls_fast,
      faiu_cls_slow,
      faiu_cls_steady
   } faiu_class_e;

   typedef struct packed {
      logic [9:0] code;
      logic [3:0] level;
      faiu_class_e cls;
   } faiu_fault_s;

   typedef struct packed {
      logic [15:0] word0;
      logic [15:0] word1;
   } faiu_cyclic_s;
endpackage : faiu_pkg

/* logic/faiu_classify.sv */
// Error code classifier: alarm class and analog error level
`timescale 1ns/1ps
`include "faiu_regs.svh"
module faiu_classify (
   // Fine error code in
   input  wire logic [9:0]            code,
   // Classification out
   output faiu_pkg::faiu_class_e      cls,
   output logic      [3:0]            level
);
   function automatic faiu_pkg::faiu_class_e class_of(input logic [9:0] c);
      if ((c >= 10'd1 && c <= 10'd7) || (c >= 10'd101 && c <= 10'd103) || c == 10'd107 || c == 10'd108
          || (c >= 10'd201 && c <= 10'd203) || c == 10'd307 || c == 10'd308 || c == 10'd801
          || (c >= 10'd900 && c <= 10'd999))
         return faiu_pkg::faiu_cls_steady;
      else if ((c >= 10'd10 && c <= 10'd12) || (c >= 10'd111 && c <= 10'd114))
         return faiu_pkg::faiu_cls_slow;
      else if (c == 10'd8 || c == 10'd9 || (c >= 10'd104 && c <= 10'd106) || c == 10'd211
               || c == 10'd302 || c == 10'd303)
         return faiu_pkg::faiu_cls_fast;
      else
         return faiu_pkg::faiu_cls_none;
   endfunction : class_of

   // Coarse 13-level mapping; codes below 13 map directly, fine code ranges fold to fixed levels, all other codes to 13
   function automatic logic [3:0] level_of(input logic [9:0] c);
      if (c >= 10'd1 && c <= 10'd12)
         return c[3:0];
      else if (c >= 10'd101 && c <= 10'd103)
         return 4'(c - 10'd100);
      else if (c >= 10'd104 && c <= 10'd106)
         return 4'h8;
      else if (c >= 10'd111 && c <= 10'd114)
         return 4'ha;
      else if (c >= 10'd900)
         return 4'h7;
      else if (c == 10'd0)
         return 4'h0;
      else
         return 4'hd;
   endfunction : level_of

   assign cls   = class_of(code);
   assign level = level_of(code);
endmodule : faiu_classify

/* logic/faiu_top.sv */
// Fault alarm indication unit: latch, lamp, relay, cyclic code, analog, hours counter, event log
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "faiu_regs.svh"
module faiu_top #(
   parameter longint STEP_CYC  = `FAIU_STEP_CYC,
   parameter int     SLOW_HALF = `FAIU_SLOW_HALF,
   parameter int     FAST_HALF = `FAIU_FAST_HALF
) (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  resetn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Fault detection from sensing logic
   input  wire logic                  fault_valid,
   input  wire logic [9:0]            fault_code,
   input  wire logic                  zero_calibration,
   // Fieldbus cyclic data
   input  wire logic                  heat_cycle_request,
   input  wire logic                  alarm_reset_request,
   input  wire logic [11:0]           measured_value,
   output faiu_pkg::faiu_cyclic_s     cyclic_in,
   output logic                       alarm_flag,
   output logic                       diag_request,
   // Indicators
   output logic                       fault_lamp,
   output logic                       alarm_relay,
   output logic      [11:0]           analog_out
);
   // The heat and reset request inputs pass a two-stage synchroniser
   logic [1:0] heat_sync_q;
   logic [1:0] rst_sync_q;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         heat_sync_q <= 2'h0;
         rst_sync_q  <= 2'h0;
      end else begin
         heat_sync_q <= {heat_sync_q[0], heat_cycle_request};
         rst_sync_q  <= {rst_sync_q[0], alarm_reset_request};
      end
   end

   // Control register
   logic [6:0] ctrl_q;
   wire heat_req   = heat_sync_q[1] | ctrl_q[`FAIU_CTRL_HEAT];
   wire reset_req  = rst_sync_q[1] | ctrl_q[`FAIU_CTRL_RESET];
   wire inv_relay  = ctrl_q[`FAIU_CTRL_INVREL];
   wire ext_diag   = ctrl_q[`FAIU_CTRL_EXTDIAG];
   wire code_wide  = ctrl_q[`FAIU_CTRL_CWIDE];
   wire ext_layout = ctrl_q[`FAIU_CTRL_EXTLAY];

   // Incoming fault classification
   faiu_pkg::faiu_class_e new_cls;
   logic [3:0]            new_lvl;
   faiu_classify u_new (
      .code  (fault_code),
      .cls   (new_cls),
      .level (new_lvl)
   );

   // Latched alarm: replaced only by an equal or more severe class
   faiu_pkg::faiu_fault_s alarm_q;
   wire alarm_active = alarm_q.cls != faiu_pkg::faiu_cls_none;
   wire take_fault   = fault_valid && new_cls != faiu_pkg::faiu_cls_none && new_cls >= alarm_q.cls;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         alarm_q <= '0;
      else if (take_fault)
         alarm_q <= '{code: fault_code, level: new_lvl, cls: new_cls};  // Set wins over reset request
      else if (reset_req)
         alarm_q <= '0;
   end

   // Blink timers; the slow phase also paces the analog alternation
   logic [26:0] slow_cnt_q;
   logic [24:0] fast_cnt_q;
   logic        slow_ph_q;
   logic        fast_ph_q;
   wire slow_wrap = slow_cnt_q == 27'(SLOW_HALF - 1);
   wire fast_wrap = fast_cnt_q == 25'(FAST_HALF - 1);
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         slow_cnt_q <= 27'h0;
         fast_cnt_q <= 25'h0;
         slow_ph_q  <= 1'b0;
         fast_ph_q  <= 1'b0;
      end else begin
         slow_cnt_q <= slow_wrap ? 27'h0 : slow_cnt_q + 27'h1;
         fast_cnt_q <= fast_wrap ? 25'h0 : fast_cnt_q + 25'h1;
         slow_ph_q  <= slow_ph_q ^ slow_wrap;
         fast_ph_q  <= fast_ph_q ^ fast_wrap;
      end
   end

   // Lamp and relay selection by class
   logic lamp_d;
   logic relay_d;
   always_comb begin
      case (alarm_q.cls)
         faiu_pkg::faiu_cls_fast: begin
            lamp_d  = fast_ph_q;
            relay_d = heat_req;
         end
         faiu_pkg::faiu_cls_slow: begin
            lamp_d  = slow_ph_q;
            relay_d = heat_req;
         end
         faiu_pkg::faiu_cls_steady: begin
            lamp_d  = 1'b1;
            relay_d = 1'b1;
         end
         default: begin
            lamp_d  = 1'b0;
            relay_d = 1'b0;
         end
      endcase
   end

   // Analog: linear temperature, error level, or alternation toward full scale
   // Product needs 16 bits before the divide, or high levels wrap
   wire [11:0] err_level = 12'(({12'h0, alarm_q.level} * 16'd4095) / 16'd15);
   wire        blink_cls = alarm_q.cls == faiu_pkg::faiu_cls_fast || alarm_q.cls == faiu_pkg::faiu_cls_slow;
   wire [11:0] analog_d  = !alarm_active ? measured_value
                         : (blink_cls && !heat_req && slow_ph_q) ? `FAIU_DAC_FULL
                         : err_level;

   // Cyclic code width and placement
   wire [9:0]  code_rep  = code_wide ? alarm_q.code : {6'h0, alarm_q.level};
   wire [15:0] word0_d   = (alarm_active && !ext_layout) ? {6'h0, code_rep} : {4'h0, measured_value};
   // Upper bits of a wide code sit above and below the coarse field so the word stays 16 bits
   wire [15:0] word1_d   = (alarm_active && ext_layout)
                           ? {code_rep[7:4], code_rep[3:0], 6'h0, code_rep[9:8]}
                           : 16'h0;

   // Registered indicator outputs
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         fault_lamp   <= 1'b0;
         alarm_relay  <= 1'b0;
         analog_out   <= 12'h0;
         cyclic_in    <= '0;
         alarm_flag   <= 1'b0;
         diag_request <= 1'b0;
      end else begin
         fault_lamp   <= lamp_d;
         alarm_relay  <= relay_d ^ inv_relay;
         analog_out   <= analog_d;
         cyclic_in    <= '{word0: word0_d, word1: word1_d};
         alarm_flag   <= alarm_active;
         diag_request <= alarm_active & ext_diag;
      end
   end

   // Operating hours counter; no write path exists, resets only model power-up
   logic [35:0] step_cnt_q;
   logic [31:0] hours_q;
   wire step_wrap = step_cnt_q == 36'(STEP_CYC - 1);
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         step_cnt_q <= 36'h0;
         hours_q    <= 32'h0;
      end else begin
         step_cnt_q <= step_wrap ? 36'h0 : step_cnt_q + 36'h1;
         if (step_wrap)
            hours_q <= hours_q + 32'h1;
      end
   end

   // Event log ring of 30 entries; bit 15 marks a zero calibration run
   logic [15:0] log_mem [`FAIU_LOG_DEPTH];
   logic [4:0]  log_wr_q;
   logic [4:0]  log_cnt_q;
   logic        fault_seen_q;
   wire new_event = take_fault && !(alarm_active && alarm_q.code == fault_code);
   wire log_event = new_event | zero_calibration;
   wire [15:0] log_entry = zero_calibration ? {1'b1, 5'h0, `FAIU_CODE_CAL} : {6'h0, fault_code};
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         log_wr_q  <= 5'h0;
         log_cnt_q <= 5'h0;
      end else if (log_event) begin
         log_wr_q  <= (log_wr_q == 5'(`FAIU_LOG_DEPTH - 1)) ? 5'h0 : log_wr_q + 5'h1;
         if (log_cnt_q != 5'(`FAIU_LOG_DEPTH - 1) + 5'h0 && log_cnt_q < 5'(`FAIU_LOG_DEPTH - 1))
            log_cnt_q <= log_cnt_q + 5'h1;
      end
   end
   always_ff @(posedge clock) begin
      if (log_event)
         log_mem[log_wr_q] <= log_entry;                       // Oldest slot overwritten
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         fault_seen_q <= 1'b0;
      else if (log_event)
         fault_seen_q <= 1'b1;
   end
   wire [5:0] log_count = fault_seen_q ? {1'b0, log_cnt_q} + 6'h1 : 6'h0;

   // APB decode; log slot n reads entry n counted from the newest
   wire        apb_acc  = psel & penable;
   wire        apb_wr   = apb_acc & pwrite;
   wire        hit_ctrl = paddr == `FAIU_CTRL_OFS;
   wire        hit_log  = paddr >= `FAIU_LOG_OFS && paddr <= `FAIU_LOG_END && paddr[1:0] == 2'h0;
   wire [4:0]  log_idx  = 5'((paddr - `FAIU_LOG_OFS) >> 2);
   wire [5:0]  rd_pos   = {1'b0, log_wr_q} + 6'd29 - {1'b0, log_idx};
   wire [4:0]  rd_slot  = 5'(rd_pos >= 6'd30 ? rd_pos - 6'd30 : rd_pos);
   wire        hit_any  = hit_ctrl || hit_log || paddr == `FAIU_STATUS_OFS || paddr == `FAIU_HOURS_OFS
                          || paddr == `FAIU_LOGCNT_OFS || paddr == `FAIU_FAULT_OFS;
   logic [31:0] rd_d;
   always_comb begin
      case (paddr)
         `FAIU_CTRL_OFS:   rd_d = {25'h0, ctrl_q};
         `FAIU_STATUS_OFS: rd_d = {26'h0, alarm_relay, fault_lamp, alarm_q.cls, heat_req, alarm_active};
         `FAIU_HOURS_OFS:  rd_d = hours_q;
         `FAIU_LOGCNT_OFS: rd_d = {26'h0, log_count};
         `FAIU_FAULT_OFS:  rd_d = {16'h0, alarm_q.level, 2'h0, alarm_q.code};
         default:          rd_d = (hit_log && {1'b0, log_idx} < log_count) ? {16'h0, log_mem[rd_slot]} : 32'h0;
      endcase
   end

   // Zero-wait slave; only the control word is writable, log and counters ignore writes
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         ctrl_q <= `FAIU_CTRL_RST;
      else if (apb_wr && hit_ctrl)
         ctrl_q <= pwdata[6:0];
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         prdata <= 32'h0;
      else if (psel && !penable && !pwrite)
         prdata <= rd_d;
   end
   assign pready  = 1'b1;
   assign pslverr = apb_acc & (!hit_any | (pwrite & !hit_ctrl));
endmodule : faiu_top

/* testbench/faiu_top_assertions.sv */
// Checker for the fault alarm unit top ports
`timescale 1ns/1ps
module faiu_top_assertions #(
   parameter longint STEP_CYC  = 20,
   parameter int     SLOW_HALF = 8,
   parameter int     FAST_HALF = 2
) (
   // Clock, reset and bus
   input wire logic        clock, resetn, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic        pready, pslverr,
   // Fault and fieldbus side
   input wire logic        fault_valid, zero_calibration, heat_cycle_request, alarm_reset_request,
   input wire logic [9:0]  fault_code,
   input wire logic [11:0] measured_value, analog_out,
   input wire faiu_pkg::faiu_cyclic_s cyclic_in,
   input wire logic        alarm_flag, diag_request, fault_lamp, alarm_relay
);
   logic        inv_q, clean_q, seen_q, lamp_q, flag_q;
   logic [9:0]  code_q;
   logic [31:0] run_q;
   logic [3:0]  heat_q;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // Shadow of polarity, last code and lamp run length; escalation spoils the blink timing
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         {inv_q, clean_q, seen_q, lamp_q, flag_q, code_q, run_q, heat_q} <= '0;
      end else begin
         if (psel && penable && pwrite && paddr == 12'h000) inv_q <= pwdata[2];
         if (fault_valid) code_q <= fault_code;
         clean_q <= alarm_flag ? (clean_q && !fault_valid) : 1'b1;
         // Lamp lighting at alarm onset is not a phase edge, so the first run is skipped
         seen_q  <= alarm_flag && (seen_q || (flag_q && fault_lamp != lamp_q));
         run_q   <= (fault_lamp != lamp_q) ? 32'd1 : run_q + 32'd1;
         lamp_q  <= fault_lamp;
         flag_q  <= alarm_flag;
         heat_q  <= {heat_q[2:0], heat_cycle_request};
      end
   end
   a_alarm_latency: assert property (fault_valid && fault_code == 10'd1 && !alarm_reset_request
      |-> ##2 alarm_flag && fault_lamp) else $error("alarm not shown two cycles after fault");
   a_latch_held: assert property ($fell(alarm_flag) |-> $past(alarm_reset_request) ||
      $past(alarm_reset_request, 2) || $past(alarm_reset_request, 3) || $past(alarm_reset_request, 4))
      else $error("alarm cleared without reset request");
   a_steady_lamp: assert property (alarm_flag && $past(alarm_flag) && code_q == 10'd1 && clean_q
      |-> fault_lamp) else $error("lamp not steady");
   a_blink_period: assert property (alarm_flag && seen_q && clean_q && fault_lamp != lamp_q
      |-> (code_q == 10'd8 && run_q == FAST_HALF) || (code_q == 10'd10 && run_q == SLOW_HALF))
      else $error("lamp blink half period wrong");
   a_steady_relay: assert property (alarm_flag && $past(alarm_flag) && code_q == 10'd1 && clean_q
      && $stable(inv_q) |-> alarm_relay == !inv_q) else $error("relay wrong in steady class");
   a_blink_relay: assert property (alarm_flag && $past(alarm_flag) && (code_q == 10'd8 || code_q == 10'd10)
      && clean_q && $stable(inv_q) && (heat_q == 4'h0 || heat_q == 4'hf)
      |-> alarm_relay == (heat_q[0] ^ inv_q)) else $error("relay wrong in blink class");
   a_analog_level: assert property (alarm_flag && $past(alarm_flag) && code_q == 10'd1 && clean_q
      |-> analog_out == 12'h111) else $error("analog error level wrong");
   a_analog_alt: assert property (alarm_flag && $past(alarm_flag) && code_q == 10'd10 && clean_q
      && heat_q == 4'h0 |-> analog_out == 12'haaa || analog_out == 12'hfff) else $error("analog not alternating");
   a_analog_hold: assert property (alarm_flag && $past(alarm_flag) && code_q == 10'd10 && clean_q
      && heat_q == 4'hf |-> analog_out == 12'haaa) else $error("analog not held");
   a_analog_normal: assert property (!alarm_flag && !$past(alarm_flag) && $past(resetn)
      |-> analog_out == $past(measured_value)) else $error("analog not tracking value");
endmodule : faiu_top_assertions

bind faiu_top faiu_top_assertions #(.STEP_CYC(STEP_CYC), .SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) chk_i (
   .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_valid(fault_valid),
   .zero_calibration(zero_calibration), .heat_cycle_request(heat_cycle_request),
   .alarm_reset_request(alarm_reset_request), .fault_code(fault_code), .measured_value(measured_value),
   .analog_out(analog_out), .cyclic_in(cyclic_in), .alarm_flag(alarm_flag), .diag_request(diag_request),
   .fault_lamp(fault_lamp), .alarm_relay(alarm_relay));

/* testbench/faiu_plc_model.sv */
// Higher-level controller model driving the request bits
`timescale 1ns/1ps
module faiu_plc_model (
   // Clock and device status
   input  wire logic clock,
   input  wire logic alarm_flag,
   input  wire logic power_down,
   // Request bits and filtered alarm
   output logic      heat_cycle_request,
   output logic      alarm_reset_request,
   output logic      alarm_seen
);
   initial begin
      heat_cycle_request  = 1'b0;
      alarm_reset_request = 1'b0;
   end
   // Alarms during power-down may be bogus, so they are masked
   assign alarm_seen = alarm_flag && !power_down;
   // Hold reset until the alarm drops or 50 cycles pass, then release it at once
   task clear_alarm;
      int n;
      n = 0;
      @(posedge clock) alarm_reset_request <= 1'b1;
      while (alarm_flag !== 1'b0 && n < 50) begin
         @(posedge clock);
         n++;
      end
      alarm_reset_request <= 1'b0;
   endtask : clear_alarm
   task set_heat(input logic v);
      @(posedge clock) heat_cycle_request <= v;
   endtask : set_heat
endmodule : faiu_plc_model

/* testbench/testbench.sv */
// Self-checking bench for the fault alarm unit
`timescale 1ns/1ps
module testbench;
   logic clock, resetn, psel, penable, pwrite, pready, pslverr, fault_valid, zero_calibration;
   logic alarm_flag, diag_request, fault_lamp, alarm_relay, heat, rstreq, power_down, alarm_seen, err;
   logic [11:0] paddr, measured_value, analog_out;
   logic [31:0] pwdata, prdata, rd, h0;
   logic [9:0]  fault_code;
   faiu_pkg::faiu_cyclic_s cyclic_in;
   int err_total, num_checks, cycles;
   faiu_top #(.STEP_CYC(20), .SLOW_HALF(8), .FAST_HALF(2)) faiu_top_i (
      .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_valid(fault_valid),
      .fault_code(fault_code), .zero_calibration(zero_calibration), .heat_cycle_request(heat),
      .alarm_reset_request(rstreq), .measured_value(measured_value), .cyclic_in(cyclic_in),
      .alarm_flag(alarm_flag), .diag_request(diag_request), .fault_lamp(fault_lamp),
      .alarm_relay(alarm_relay), .analog_out(analog_out));
   faiu_plc_model faiu_plc_model_i (.clock(clock), .alarm_flag(alarm_flag), .power_down(power_down),
      .heat_cycle_request(heat), .alarm_reset_request(rstreq), .alarm_seen(alarm_seen));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Cut a hang short
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         end_of_test();
      end
   end
   task end_of_test;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   // One APB transfer; the wait for pready has no timeout of its own beyond the bench timeout
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
      @(posedge clock) penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task fault(input logic [9:0] c);
      @(posedge clock) {fault_valid, fault_code} <= {1'b1, c};
      @(posedge clock) fault_valid <= 1'b0;
      cyc(3);
   endtask : fault
   initial begin
      {resetn, psel, penable, pwrite, paddr, pwdata, fault_valid, fault_code, zero_calibration} = '0;
      {power_down, err_total, num_checks, cycles} = '0;
      measured_value = 12'h123;
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      apb(0, 12'h000, 0);
      chk("ctrl reset", 0, rd);
      apb(0, 12'h040, 0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      apb(1, 12'h004, 0);
      chk("status wr err", 1, err);
      apb(1, 12'h008, 0);
      chk("hours wr err", 1, err);
      cyc(1);
      chk("analog normal", 12'h123, analog_out);
      apb(0, 12'h008, 0);
      h0 = rd;
      cyc(37);
      apb(0, 12'h008, 0);
      chk("hours step", 2, rd - h0);
      // Overfill the log with calibration entries
      repeat (32) begin
         @(posedge clock) zero_calibration <= 1'b1;
         @(posedge clock) zero_calibration <= 1'b0;
      end
      apb(0, 12'h00c, 0);
      chk("log count", 30, rd);
      apb(0, 12'h080, 0);
      chk("log newest", 32'h83ff, rd[15:0]);
      apb(1, 12'h080, 0);
      chk("log wr err", 1, err);
      apb(1, 12'h000, 32'h28);
      fault(10'd8);
      chk("alarm flag", 1, alarm_flag);
      chk("ext code", 4'h8, cyclic_in.word1[11:8]);
      chk("diag", 1, diag_request);
      chk("relay fast", 0, alarm_relay);
      apb(0, 12'h010, 0);
      chk("fine code", 10'd8, rd[9:0]);
      faiu_plc_model_i.set_heat(1);
      cyc(5);
      chk("relay heat", 1, alarm_relay);
      faiu_plc_model_i.set_heat(0);
      fault(10'd10);
      fault(10'd8);
      apb(0, 12'h004, 0);
      chk("class slow", 2, rd[3:2]);
      faiu_plc_model_i.set_heat(1);
      cyc(5);
      chk("analog hold", 12'haaa, analog_out);
      faiu_plc_model_i.set_heat(0);
      apb(1, 12'h000, 32'h04);
      cyc(5);
      chk("relay inv", 1, alarm_relay);
      chk("compact code", 4'ha, cyclic_in.word0[3:0]);
      fault(10'd1);
      chk("lamp steady", 1, fault_lamp);
      chk("relay inv steady", 0, alarm_relay);
      chk("analog level", 12'h111, analog_out);
      apb(1, 12'h000, 0);
      cyc(3);
      chk("relay steady", 1, alarm_relay);
      apb(1, 12'h000, 32'h10);
      cyc(2);
      chk("wide code", 10'd1, cyclic_in.word0[9:0]);
      cyc(20);
      chk("latched", 1, alarm_flag);
      faiu_plc_model_i.clear_alarm();
      cyc(5);
      chk("cleared", 0, alarm_flag);
      // A new temperature must reach both the analog pin and the cyclic word
      @(posedge clock) measured_value <= 12'h456;
      cyc(2);
      chk("analog track", 12'h456, analog_out);
      chk("value word", 16'h0456, cyclic_in.word0);
      apb(0, 12'h00c, 0);
      chk("log kept", 30, rd);
      // A clean slow-class alarm lets the blink and alternation checks run
      fault(10'd10);
      cyc(20);
      chk("relay slow", 0, alarm_relay);
      @(posedge clock) power_down <= 1'b1;
      fault(10'd1);
      chk("masked", 0, alarm_seen);
      end_of_test();
   end
endmodule : testbench
